// >>> cps_cfg_source.sv
// Purpose: Far side of the loader: passive host and serial configuration memory.
// Assumes: Bit clock only runs inside a frame; memory samples command on rising clock.
// Notes: Undriven data line shows the inverse of its last value.
`timescale 1ns/1ps
module cps_cfg_source #(
	parameter int NB = 8
) (
	input wire logic go_ps, // Rising edge starts a passive frame
	input wire logic one_byte, // Frame carries only the first byte
	input wire logic [8*NB-1:0] image, // Bytes, first byte at the top
	input wire cps_pkg::cps_flash_t flash, // Active-mode pins of the device
	output logic bit_clk, // Passive bit clock
	output logic data, // Serial data line
	output logic [31:0] cmd_word, // Command seen by the memory
	output logic cmd_done // High once 32 command bits arrived
);
	int n_rise;
	wire sck = flash.sck & flash.sck_oe;
	wire sel = flash.sel_n;

	initial
	begin
		bit_clk = 1'h0;
		data = 1'h0;
		cmd_word = 32'h0;
		cmd_done = 1'h0;
		n_rise = 0;
	end

	// Two pad clocks, then bits msb first; data moves on the falling clock
	always @(posedge go_ps)
	begin
		for (int i = 0; i < (one_byte ? 8 : 8 * NB) + 2; i++)
		begin
			data = (i < 2) ? ~data : image[8*NB+1-i];
			#62.5 bit_clk = 1'h1;
			#62.5 bit_clk = 1'h0;
		end
		data = ~data;
	end

	// Memory restarts its read whenever it is deselected
	always @(posedge sck or posedge sel)
		if (sel)
		begin
			n_rise = 0;
			cmd_done = 1'h0;
			data = ~data;
		end
		else
		begin
			if (n_rise < 32)
				cmd_word = {cmd_word[30:0], flash.cmd};
			n_rise++;
			cmd_done = (n_rise >= 32);
		end

	// Memory shifts data out after each falling clock past the command
	always @(negedge sck)
		if (!sel && n_rise >= 32 && n_rise < 32 + 8 * NB)
			data = image[8*NB-1-(n_rise-32)];
		else
			data = ~data;
endmodule

// >>> cps_pkg.sv
// Purpose: Shared constants and types of the configuration pin sequencer.
// Assumes: ref_clk at 40 MHz; cfg_bit_clock is a separate link clock.
// Notes: Timing counts assume the 40 MHz reference clock.
package cps_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int POR_HOLD_US = 5;
	// Longest time, so the division rounds down
	localparam int POR_HOLD_CYC = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;
	localparam int MEM_HOLD_MS = 200;
	localparam int ERR_HOLD_CYC = 8;
	// Serial read framing
	localparam int AS_CMD_BITS = 32;
	localparam int BYTE_BITS = 8;
	// Reset values of the pin flops
	localparam logic RST_STATUS_OE = 1'h1;
	localparam logic RST_DONE_OE = 1'h1;
	localparam logic RST_CHAIN_OUT_N = 1'h1;
	localparam logic RST_INIT_OE = 1'h0;
	localparam logic RST_IO_EN = 1'h0;

	typedef enum logic [1:0]
	{
		SCH_PS = 2'b00,
		SCH_AS = 2'b01,
		SCH_RSV2 = 2'b10,
		SCH_RSV3 = 2'b11
	} cps_scheme_t;

	typedef enum logic [2:0]
	{
		ST_POR = 3'b000,
		ST_RESET = 3'b001,
		ST_CONFIG = 3'b010,
		ST_INIT = 3'b011,
		ST_USER = 3'b100,
		ST_ERROR = 3'b101
	} cps_state_t;

	// Pins toward the serial configuration memory
	typedef struct packed
	{
		logic sck;
		logic sck_oe;
		logic cmd;
		logic sel_n;
	} cps_flash_t;
endpackage

// >>> cps_ps_capture.sv
// Purpose: Passive serial capture on the external bit clock.
// Assumes: The bit clock runs only while data is sent.
// Notes: A byte stays stable eight link edges after its toggle.
`timescale 1ns/1ps
module cps_ps_capture (
	input wire logic link_clk, // External bit clock
	input wire logic rst_n, // Async reset, active low
	input wire logic en_ref, // Capture enable from ref domain
	input wire logic data_in, // Serial data pin
	output logic [7:0] byte_o, // Last complete byte
	output logic tog_o // Toggles per byte
);
	logic en_meta_ff;
	logic en_ff;
	logic arm_n;
	logic [2:0] bit_ff;
	logic [6:0] sh_ff;

	// Disarm at once: the bit clock stops after a frame, so a clocked drop would never land
	assign arm_n = rst_n & en_ref;

	// Enable crossing; clears at once, re-arms after two leading edges of the bit clock
	always_ff @(posedge link_clk or negedge arm_n)
	begin
		if (!arm_n)
		begin
			en_meta_ff <= 1'h0;
			en_ff <= 1'h0;
		end
		else
		begin
			en_meta_ff <= 1'h1;
			en_ff <= en_meta_ff;
		end
	end

	// Shift msb first and hand each byte over by a toggle
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_ff <= 3'h0;
			sh_ff <= 7'h00;
			byte_o <= 8'h00;
			tog_o <= 1'h0;
		end
		else if (!en_ff)
			bit_ff <= 3'h0;
		else
		begin
			sh_ff <= {sh_ff[5:0], data_in};
			bit_ff <= bit_ff + 3'h1;
			if (bit_ff == 3'h7)
			begin
				byte_o <= {sh_ff, data_in};
				tog_o <= ~tog_o;
			end
		end
	end
endmodule

// >>> cps_sequencer.sv
// Purpose: Configuration pin sequencer of a programmable device.
// Assumes: Open-drain pins resolved outside; pins are asynchronous.
// Notes: Passive data crosses from cfg_bit_clock by toggle.
`timescale 1ns/1ps
module cps_sequencer #(
	parameter int CFG_BYTES = 16,
	parameter logic [7:0] SYNC_BYTE = 8'ha5,
	parameter logic [7:0] AS_READ_CMD = 8'h03,
	parameter int AS_HALF = 2,
	parameter int INIT_TICKS = 8
) (
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic rst_n, // Power-on reset, active low
	input wire logic scheme_select_hi, // Scheme select, upper bit
	input wire logic scheme_select_lo, // Scheme select, lower bit
	input wire logic status_open_drain_n_i, // Status line level
	output logic status_open_drain_n_o, // Status drive value, always low
	output logic status_open_drain_n_oe, // High pulls status low
	input wire logic config_request_n, // Host reset and start request
	input wire logic load_complete_i, // Load complete line level
	output logic load_complete_o, // Load complete drive value
	output logic load_complete_oe, // High pulls load complete low
	input wire logic cfg_bit_clock_i, // Passive bit clock (link clock)
	output cps_pkg::cps_flash_t flash_o, // Active clock, command, select
	input wire logic cfg_data_in, // Serial configuration data
	input wire logic chain_enable_in_n, // Chain enable from upstream
	output logic chain_enable_out_n, // Chain enable to next device
	input wire logic user_init_clock, // Optional init clock
	input wire logic user_init_clk_en, // Use user_init_clock for init
	input wire logic init_flag_en, // Init flag output enabled
	output logic init_complete_flag_o, // Init flag drive value
	output logic init_complete_flag_oe, // High pulls init flag low
	output logic user_io_enable, // User pins may drive
	output logic user_mode // Device in user mode
);
	if (CFG_BYTES < 2 || CFG_BYTES > 65535 || AS_HALF < 2 || AS_HALF > 127
		|| INIT_TICKS < 1 || INIT_TICKS > 65535)
	begin : g_bad_param
		$error("cps_sequencer: parameter out of range");
	end

	cps_pkg::cps_state_t st_ff;
	cps_pkg::cps_state_t nxt_st;
	cps_pkg::cps_scheme_t scheme_ff;
	logic [10:0] pin_s;
	logic sel_hi_s, sel_lo_s, status_s, cfgreq_s, done_s;
	logic chain_in_s, uic_s, data_s, tog_s, uic_en_s, flag_en_s;
	logic [15:0] cnt_ff;
	logic [15:0] bytes_ff;
	logic [15:0] ticks_ff;
	logic tog_d_ff;
	logic uic_d_ff;
	logic ps_en_ff;
	logic [7:0] ps_byte;
	logic ps_tog;
	logic as_act;
	logic [7:0] as_ph_ff;
	logic [5:0] as_cmdn_ff;
	logic [31:0] as_sh_ff;
	logic [7:0] as_rx_ff;
	logic [2:0] as_rxn_ff;
	logic as_ev_ff;
	logic as_slot_end;
	logic byte_ev;
	logic [7:0] byte_val;
	logic tick;
	logic init_hold;

	// Every input pin but ref_clk, cfg_bit_clock_i and reset (user_init_clock included), and the link toggle, pass two flops first
	cps_sync #(
		.W(11)
	) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.d({scheme_select_hi, scheme_select_lo, status_open_drain_n_i,
			config_request_n, load_complete_i, chain_enable_in_n,
			user_init_clock, cfg_data_in, ps_tog, user_init_clk_en, init_flag_en}),
		.q(pin_s)
	);
	assign {sel_hi_s, sel_lo_s, status_s, cfgreq_s, done_s, chain_in_s,
		uic_s, data_s, tog_s, uic_en_s, flag_en_s} = pin_s;

	// Passive capture lives in the bit clock domain
	cps_ps_capture u_ps (
		.link_clk(cfg_bit_clock_i),
		.rst_n(rst_n),
		.en_ref(ps_en_ff),
		.data_in(cfg_data_in),
		.byte_o(ps_byte),
		.tog_o(ps_tog)
	);

	// Byte events from either source; passive byte is stable on toggle
	assign as_act = (st_ff == cps_pkg::ST_CONFIG) && (scheme_ff == cps_pkg::SCH_AS);
	assign byte_ev = (scheme_ff == cps_pkg::SCH_AS) ? as_ev_ff : (tog_s ^ tog_d_ff);
	assign byte_val = (scheme_ff == cps_pkg::SCH_AS) ? as_rx_ff : ps_byte;
	assign as_slot_end = as_ph_ff == 8'(2 * AS_HALF - 1);

	// Init pacing; memory-sourced loads ignore external hold
	assign tick = uic_en_s ? (uic_s & ~uic_d_ff) : 1'h1;
	assign init_hold = !done_s && (scheme_ff != cps_pkg::SCH_AS);

	// Sequence state decision
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			cps_pkg::ST_POR:
				if (cnt_ff == 16'(cps_pkg::POR_HOLD_CYC - 1))
					nxt_st = cps_pkg::ST_RESET;
			cps_pkg::ST_RESET:
				// A memory may keep status low long; just wait
				if (cfgreq_s && status_s && !chain_in_s)
					nxt_st = cps_pkg::ST_CONFIG;
			cps_pkg::ST_CONFIG:
				if (!status_s)
					nxt_st = cps_pkg::ST_ERROR;
				else if (byte_ev && bytes_ff == 16'h0000 && byte_val != SYNC_BYTE)
					nxt_st = cps_pkg::ST_ERROR;
				else if (byte_ev && bytes_ff == 16'(CFG_BYTES - 1))
					nxt_st = cps_pkg::ST_INIT;
			cps_pkg::ST_INIT:
				if (!status_s)
					nxt_st = cps_pkg::ST_ERROR;
				else if (tick && !init_hold && ticks_ff == 16'(INIT_TICKS - 1))
					nxt_st = cps_pkg::ST_USER;
			cps_pkg::ST_USER:
				nxt_st = cps_pkg::ST_USER;
			cps_pkg::ST_ERROR:
				if (cnt_ff == 16'(cps_pkg::ERR_HOLD_CYC - 1))
					nxt_st = cps_pkg::ST_RESET;
			default:
				nxt_st = cps_pkg::ST_RESET;
		endcase
		// A low request overrides everything once power-up is done
		if (!cfgreq_s && st_ff != cps_pkg::ST_POR)
			nxt_st = cps_pkg::ST_RESET;
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= cps_pkg::ST_POR;
		else
			st_ff <= nxt_st;
	end

	// Dwell counter for power-up and error pulses
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_ff <= 16'h0000;
		else if (nxt_st != st_ff)
			cnt_ff <= 16'h0000;
		else
			cnt_ff <= cnt_ff + 16'h0001;
	end

	// Scheme latched at start; pins ignored from then on
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			scheme_ff <= cps_pkg::SCH_PS;
		else if (st_ff == cps_pkg::ST_RESET && nxt_st == cps_pkg::ST_CONFIG)
			scheme_ff <= cps_pkg::cps_scheme_t'({sel_hi_s, sel_lo_s});
	end

	// Byte and init tick counters, edge history
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bytes_ff <= 16'h0000;
			ticks_ff <= 16'h0000;
			tog_d_ff <= 1'h0;
			uic_d_ff <= 1'h0;
			ps_en_ff <= 1'h0;
		end
		else
		begin
			tog_d_ff <= tog_s;
			uic_d_ff <= uic_s;
			// Passive capture armed only while loading, so late edges are harmless
			ps_en_ff <= (nxt_st == cps_pkg::ST_CONFIG) && (scheme_ff != cps_pkg::SCH_AS);
			if (st_ff != cps_pkg::ST_CONFIG)
				bytes_ff <= 16'h0000;
			else if (byte_ev)
				bytes_ff <= bytes_ff + 16'h0001;
			if (st_ff != cps_pkg::ST_INIT)
				ticks_ff <= 16'h0000;
			else if (tick && !init_hold)
				ticks_ff <= ticks_ff + 16'h0001;
		end
	end

	// Active serial reader: read command, then bytes msb first
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			as_ph_ff <= 8'h00;
			as_cmdn_ff <= 6'h00;
			as_sh_ff <= 32'h0000_0000;
			as_rx_ff <= 8'h00;
			as_rxn_ff <= 3'h0;
			as_ev_ff <= 1'h0;
		end
		else if (!as_act)
		begin
			as_ph_ff <= 8'h00;
			as_cmdn_ff <= 6'h00;
			as_sh_ff <= {AS_READ_CMD, 24'h00_0000};
			as_rxn_ff <= 3'h0;
			as_ev_ff <= 1'h0;
		end
		else
		begin
			as_ev_ff <= 1'h0;
			as_ph_ff <= as_slot_end ? 8'h00 : as_ph_ff + 8'h01;
			if (as_slot_end && as_cmdn_ff != 6'(cps_pkg::AS_CMD_BITS))
			begin
				as_sh_ff <= {as_sh_ff[30:0], 1'h0};
				as_cmdn_ff <= as_cmdn_ff + 6'h01;
			end
			else if (as_slot_end)
			begin
				// Synced data still shows the level from the high phase
				as_rx_ff <= {as_rx_ff[6:0], data_s};
				as_rxn_ff <= as_rxn_ff + 3'h1;
				as_ev_ff <= as_rxn_ff == 3'(cps_pkg::BYTE_BITS - 1);
			end
		end
	end

	// Memory pins; clock driven only while loading, then released
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			flash_o <= '{sck: 1'h0, sck_oe: 1'h0, cmd: 1'h0, sel_n: 1'h1};
		else
		begin
			flash_o.sel_n <= !as_act;
			flash_o.sck_oe <= as_act;
			flash_o.sck <= as_act && (as_ph_ff == 8'(AS_HALF - 1) || (flash_o.sck
				&& !as_slot_end));
			flash_o.cmd <= (as_act && as_slot_end) ? as_sh_ff[30] : as_sh_ff[31];
		end
	end

	// Pin flops follow the next state so they change with it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_open_drain_n_oe <= cps_pkg::RST_STATUS_OE;
			load_complete_oe <= cps_pkg::RST_DONE_OE;
			chain_enable_out_n <= cps_pkg::RST_CHAIN_OUT_N;
			init_complete_flag_oe <= cps_pkg::RST_INIT_OE;
			user_io_enable <= cps_pkg::RST_IO_EN;
			user_mode <= 1'h0;
			status_open_drain_n_o <= 1'h0;
			load_complete_o <= 1'h0;
			init_complete_flag_o <= 1'h0;
		end
		else
		begin
			status_open_drain_n_oe <= nxt_st == cps_pkg::ST_POR || nxt_st == cps_pkg::ST_ERROR
				|| (nxt_st == cps_pkg::ST_RESET && !cfgreq_s);
			load_complete_oe <= nxt_st == cps_pkg::ST_POR || nxt_st == cps_pkg::ST_RESET
				|| nxt_st == cps_pkg::ST_CONFIG || nxt_st == cps_pkg::ST_ERROR;
			chain_enable_out_n <= nxt_st != cps_pkg::ST_USER;
			init_complete_flag_oe <= flag_en_s && (nxt_st == cps_pkg::ST_CONFIG
				|| nxt_st == cps_pkg::ST_INIT);
			user_io_enable <= nxt_st == cps_pkg::ST_USER && cfgreq_s;
			user_mode <= nxt_st == cps_pkg::ST_USER;
		end
	end

	// Checks, all in the ref_clk domain
	localparam int ERR_MAX = 8;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_enter_user;
		st_ff == cps_pkg::ST_INIT ##1 st_ff == cps_pkg::ST_USER;
	endsequence

	a_scheme_hold: assert property ((st_ff != cps_pkg::ST_RESET) |=> $stable(scheme_ff))
		else $error("scheme changed outside reset state");
	// Power-up is only entered by reset, so bound its length by the dwell counter
	a_por_release: assert property (
		(st_ff == cps_pkg::ST_POR) |-> status_open_drain_n_oe
		&& cnt_ff < 16'(cps_pkg::POR_HOLD_CYC))
		else $error("status not released within power-up window");
	a_error_pulse: assert property (
		(st_ff == cps_pkg::ST_ERROR) |-> status_open_drain_n_oe
		##[1:ERR_MAX] st_ff != cps_pkg::ST_ERROR)
		else $error("error state without status drive or stuck");
	a_ext_status: assert property (
		(st_ff == cps_pkg::ST_CONFIG || st_ff == cps_pkg::ST_INIT) && !status_s && cfgreq_s
		|=> st_ff == cps_pkg::ST_ERROR)
		else $error("external status low not taken as error");
	a_req_reset: assert property (
		$fell(cfgreq_s) && $past(st_ff) != cps_pkg::ST_POR |=> st_ff == cps_pkg::ST_RESET)
		else $error("request low did not reset the sequence");
	a_io_tristate: assert property (!cfgreq_s |=> !user_io_enable)
		else $error("user pins enabled while request low");
	a_done_low: assert property ((st_ff == cps_pkg::ST_CONFIG) |-> load_complete_oe)
		else $error("load complete released during loading");
	a_user_hold: assert property (
		(st_ff == cps_pkg::ST_USER) && cfgreq_s |=> st_ff == cps_pkg::ST_USER)
		else $error("user mode left without request");
	a_user_flags: assert property (
		s_enter_user |-> !chain_enable_out_n && !init_complete_flag_oe && user_mode)
		else $error("user mode entered without completion pins");
	a_status_gate: assert property (
		(st_ff == cps_pkg::ST_RESET) && !status_s |=> st_ff != cps_pkg::ST_CONFIG)
		else $error("loading began while status low");
	// The flag flop follows the enable of the cycle before
	a_init_flag: assert property (
		(st_ff == cps_pkg::ST_CONFIG || st_ff == cps_pkg::ST_INIT) && $past(flag_en_s)
		|-> init_complete_flag_oe)
		else $error("init flag not driven low during configuration");
endmodule

// >>> cps_sync.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a level; no bus coherency across bits.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module cps_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [W-1:0] d, // Asynchronous levels
	output logic [W-1:0] q // Synchronised levels
);
	logic [W-1:0] meta_ff;

	// Two stages; the first is read by the second alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench of the configuration pin sequencer.
// Assumes: Open-drain lines have pull-ups; events are matched in order.
// Notes: The long memory hold of status is shortened to 2000 cycles.
`timescale 1ns/1ps
module testbench;
	localparam int NB = 8;
	localparam logic [7:0] SYNC = 8'ha5;
	localparam logic [7:0] RCMD = 8'h03;
	typedef struct packed {logic [1:0] kind; logic [31:0] val;} cps_note_t;
	cps_note_t notes[$];
	int n_fail = 0;
	int comparisons = 0;
	int run;
	logic run_ok, mode_q, cmd_q, uclk_run;
	logic [1:0] mwait;
	logic ref_clk, rst_n, sel_hi, sel_lo, req_n, pull_stat, pull_load, chain_in_n;
	logic uclk, uclk_en, flag_en, go_ps, one_byte;
	logic [8*NB-1:0] image;
	logic [63:0] rnd;
	logic [31:0] seed;
	logic stat_o, stat_oe, load_o, load_oe, chain_out_n, init_o, init_oe, io_en, umode;
	logic bit_clk, sdata, cmd_done;
	logic [31:0] cmd_word;
	cps_pkg::cps_flash_t flash;
	wire stat_w = ~(stat_oe | pull_stat);
	wire load_w = ~(load_oe | pull_load);

	cps_sequencer #(.CFG_BYTES(NB), .SYNC_BYTE(SYNC), .AS_READ_CMD(RCMD)) cps_sequencer_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .scheme_select_hi(sel_hi), .scheme_select_lo(sel_lo),
		.status_open_drain_n_i(stat_w), .status_open_drain_n_o(stat_o),
		.status_open_drain_n_oe(stat_oe), .config_request_n(req_n), .load_complete_i(load_w),
		.load_complete_o(load_o), .load_complete_oe(load_oe), .cfg_bit_clock_i(bit_clk),
		.flash_o(flash), .cfg_data_in(sdata), .chain_enable_in_n(chain_in_n),
		.chain_enable_out_n(chain_out_n), .user_init_clock(uclk), .user_init_clk_en(uclk_en),
		.init_flag_en(flag_en), .init_complete_flag_o(init_o), .init_complete_flag_oe(init_oe),
		.user_io_enable(io_en), .user_mode(umode));

	cps_cfg_source #(.NB(NB)) cps_cfg_source_inst (.go_ps(go_ps), .one_byte(one_byte),
		.image(image), .flash(flash), .bit_clk(bit_clk), .data(sdata), .cmd_word(cmd_word),
		.cmd_done(cmd_done));

	always #12.5 ref_clk = ~ref_clk;
	always #100 uclk = uclk_run ? ~uclk : uclk;

	task automatic note(input logic [1:0] k, input logic [31:0] v);
		notes.push_back({k, v});
	endtask

	task automatic check(input logic [1:0] k, input logic [31:0] v);
		cps_note_t n;
		comparisons++;
		if (notes.size() == 0)
		begin
			n_fail++;
			$display("BAD %0t unexpected event kind %0d value %h", $time, k, v);
		end
		else
		begin
			n = notes.pop_front();
			if (n !== {k, v})
			begin
				n_fail++;
				$display("BAD %0t kind %0d got %h want kind %0d %h", $time, k, v, n.kind, n.val);
			end
		end
	endtask

	// Watcher: mode tuple once settled, status pulse lengths, memory command
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			mode_q <= 1'h0;
			mwait <= 2'h0;
			run <= 0;
			run_ok <= 1'h1;
			cmd_q <= 1'h0;
		end
		else
		begin
			if (umode !== mode_q)
				mwait <= 2'h3;
			else if (mwait != 2'h0)
				mwait <= mwait - 2'h1;
			mode_q <= umode;
			if (mwait == 2'h1)
				check(2'h0, {24'h0, stat_o, load_o, init_o,
					umode, io_en, chain_out_n, load_oe, init_oe});
			// Pulses overlapping a host request have host-set length, so skip them
			if (stat_oe)
			begin
				run <= run + 1;
				if (!req_n)
					run_ok <= 1'h0;
			end
			else
			begin
				if (run != 0 && run_ok)
					check(2'h1, run);
				run <= 0;
				run_ok <= 1'h1;
			end
			if (cmd_done && !cmd_q)
				check(2'h2, cmd_word);
			cmd_q <= cmd_done;
		end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic idle(input int n);
		int i;
		i = 0;
		while (notes.size() != 0 && i < n)
		begin
			cyc(1);
			i++;
		end
		if (notes.size() != 0)
		begin
			n_fail++;
			$display("BAD %0t expected event missing", $time);
		end
		notes.delete();
	endtask

	task automatic set_image(input logic bad);
		rnd = {$urandom, $urandom};
		image <= {bad ? ~SYNC : SYNC, rnd[8*NB-9:0]};
	endtask

	// Host waits for status to read high before clocking data in
	task automatic run_ps(input logic bad);
		int i;
		i = 0;
		while (stat_w !== 1'b1 && i < 5000)
		begin
			cyc(1);
			i++;
		end
		if (stat_w !== 1'b1)
		begin
			n_fail++;
			$display("BAD %0t status line never released", $time);
		end
		set_image(bad);
		one_byte <= bad;
		cyc(10);
		go_ps <= 1'h1;
		cyc(1);
		go_ps <= 1'h0;
	endtask

	task automatic req_pulse;
		req_n <= 1'h0;
		cyc(20);
		req_n <= 1'h1;
	endtask

	task automatic end_sim;
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#1000000;
		n_fail++;
		end_sim();
	end

	initial
	begin
		ref_clk = 1'h0;
		rst_n = 1'h0;
		{sel_hi, sel_lo, pull_stat, pull_load, uclk, uclk_en, uclk_run, go_ps, one_byte} = 9'h0;
		req_n = 1'h1;
		chain_in_n = 1'h0;
		flag_en = 1'h1;
		image = '0;
		seed = $urandom(32'h2a11);
		note(2'h1, cps_pkg::POR_HOLD_CYC);
		note(2'h0, 32'h18);
		cyc(12);
		rst_n <= 1'h1;
		run_ps(1'h0);
		idle(2000);
		// User mode must shrug off status, load complete and scheme pins
		pull_stat <= 1'h1;
		pull_load <= 1'h1;
		sel_hi <= 1'h1;
		cyc(30);
		pull_stat <= 1'h0;
		pull_load <= 1'h0;
		cyc(30);
		note(2'h0, 32'h06);
		pull_stat <= 1'h1;
		req_pulse();
		cyc(2000);
		pull_stat <= 1'h0;
		idle(100);
		note(2'h1, cps_pkg::ERR_HOLD_CYC);
		run_ps(1'h1);
		idle(1000);
		cyc(60);
		note(2'h1, cps_pkg::ERR_HOLD_CYC);
		pull_stat <= 1'h1;
		cyc(4);
		pull_stat <= 1'h0;
		idle(200);
		// Outside party stretches load complete to postpone initialisation
		pull_load <= 1'h1;
		run_ps(1'h0);
		cyc(800);
		note(2'h0, 32'h18);
		pull_load <= 1'h0;
		idle(200);
		// Active scheme, with the user init clock held still at first
		sel_hi <= 1'h0;
		sel_lo <= 1'h1;
		uclk_en <= 1'h1;
		set_image(1'h0);
		note(2'h0, 32'h06);
		note(2'h2, {RCMD, 24'h0});
		req_pulse();
		cyc(1200);
		note(2'h0, 32'h18);
		uclk_run <= 1'h1;
		idle(2000);
		end_sim();
	end
endmodule
